// File: include/timed_output_fifo_diag_pkg.sv
// Constants for the timed output queue and its diagnostic record.
// Assumes one clock domain shared with the backplane logic.
package timed_output_fifo_diag_pkg;
  // Entry word layout: [7:0] output/enable bits, [15:8] sequence, [31:16] target time
  localparam int ENTRY_W = 32;
  localparam int BITS_LSB = 0;
  localparam int SEQ_LSB = 8;
  localparam int TIME_LSB = 16;
  localparam int TIME_W = 16;
  localparam int DO0_BIT = 7;
  localparam int DO1_BIT = 6;
  localparam int EN0_BIT = 5;
  localparam int EN1_BIT = 4;
  localparam int LAST_FLAG_BIT = 6;
  localparam int FIFO_DEPTH = 32;
  // Queue status bits
  localparam int QS_END_BIT = 7;
  localparam int QS_RUN_BIT = 1;
  localparam int NEXT_VALID_BIT = 7;
  // Access paths to the diagnostic record
  typedef enum logic [1:0] {REC_SET, REC_CANOPEN, REC_ETHERCAT} rec_path_t;
  localparam logic [15:0] RECORD_SET_SHORT = 16'h0000;
  localparam logic [15:0] RECORD_SET_FULL = 16'h0001;
  localparam logic [15:0] CAN_INDEX_SHORT = 16'h2f00;
  localparam logic [15:0] CAN_INDEX_FULL = 16'h2f01;
  localparam logic [15:0] ECAT_INDEX = 16'h5005;
  localparam logic [7:0] ECAT_SUB_FIRST = 8'h02;
  localparam logic [7:0] ECAT_SUB_LAST_ERR = 8'h11;
  localparam logic [7:0] ECAT_SUB_TICKER = 8'h13;
  localparam logic [4:0] SHORT_LEN = 5'h04;
  localparam logic [4:0] RECORD_LEN = 5'h14;
  localparam logic [4:0] TICKER_OFS = 5'h10;
  // Record byte values
  localparam logic [7:0] ERROR_BYTE_A_VAL = 8'h00;
  localparam logic [7:0] MODULE_CLASS_INFO_VAL = 8'h1f;
  localparam logic [7:0] ERROR_BYTE_C_VAL = 8'h00;
  localparam logic [7:0] ERROR_BYTE_D_VAL = 8'h00;
  localparam logic [7:0] CHANNEL_KIND_VAL = 8'h72;
  localparam logic [7:0] DIAG_BITS_PER_CHANNEL_VAL = 8'h00;
  localparam logic [7:0] CHANNEL_COUNT_VAL = 8'h02;
  localparam logic [7:0] CHANNEL_ERROR_SUMMARY_VAL = 8'h00;
  localparam logic [7:0] PER_CHANNEL_ERRORS_VAL = 8'h00;
endpackage : timed_output_fifo_diag_pkg

// File: hdl/timed_output_fifo_diag.sv
// Timed output queue with microsecond schedule and read-only diagnostic record.
// Assumes entry strobes, ticker and record requests come from logic on i_clk.
`timescale 1ns/10ps
`default_nettype none
module timed_output_fifo_diag #(
  parameter int DEPTH = timed_output_fifo_diag_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Entry stream from the output process image
  input wire logic i_entry_valid,
  input wire logic [timed_output_fifo_diag_pkg::ENTRY_W-1:0] i_entry_data,
  output logic o_entry_ready,
  // Ticker from the head module
  input wire logic i_ticker_present,
  input wire logic [31:0] i_us_ticker,
  // Digital outputs
  output logic [1:0] o_do,
  // Status for the input process image
  output logic [7:0] o_last_received_sequence,
  output logic [7:0] o_next_execute_sequence,
  output logic [7:0] o_queue_status,
  output logic [7:0] o_pending_entry_count,
  // Diagnostic record byte read
  input wire logic i_rec_valid,
  input wire timed_output_fifo_diag_pkg::rec_path_t i_rec_path,
  input wire logic [15:0] i_rec_id,
  input wire logic [7:0] i_rec_sub,
  input wire logic [4:0] i_rec_byte,
  output logic o_rec_valid,
  output logic [7:0] o_rec_data,
  output logic o_rec_err
);
  import timed_output_fifo_diag_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [ENTRY_W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [31:0] ts_reg;
  logic push;
  logic pop;
  logic [ENTRY_W-1:0] head;
  logic time_hit;
  logic [1:0] en_next;
  logic [1:0] st_next;

  assign head = mem[rd_ptr_reg];
  assign push = i_entry_valid && o_entry_ready;
  // Compare against the head module's ticker; nothing runs without it
  assign time_hit = i_ticker_present &&
                    (i_us_ticker[TIME_W-1:0] == head[TIME_LSB +: TIME_W]);
  assign pop = (count_reg != '0) && time_hit;

  // Queue storage and pointers
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_entry_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      o_entry_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= AW'((wr_ptr_reg + 1'b1) % DEPTH);
      end
      if (pop) begin
        rd_ptr_reg <= AW'((rd_ptr_reg + 1'b1) % DEPTH);
      end
      case ({push, pop})
        2'b10: begin
          count_reg <= count_reg + 1'b1;
          o_entry_ready <= (count_reg + 1'b1) < CW'(DEPTH);
        end
        2'b01: begin
          count_reg <= count_reg - 1'b1;
          o_entry_ready <= 1'b1;
        end
        default: begin
          count_reg <= count_reg;
          o_entry_ready <= o_entry_ready;
        end
      endcase
    end
  end

  // Enables latch per entry; a state bit drives only an enabled output
  always_comb begin
    en_next = {head[BITS_LSB + EN1_BIT], head[BITS_LSB + EN0_BIT]};
    st_next = {head[BITS_LSB + DO1_BIT], head[BITS_LSB + DO0_BIT]};
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_do <= 2'h0;
    end else if (pop) begin
      o_do <= st_next & en_next;
    end
  end

  // Sequence and queue status
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_last_received_sequence <= 8'h00;
      o_next_execute_sequence <= 8'h00;
      o_queue_status <= 8'h00;
      o_pending_entry_count <= 8'h00;
    end else begin
      if (push) begin
        o_last_received_sequence <= i_entry_data[SEQ_LSB +: 8];
      end
      if (count_reg != '0) begin
        o_next_execute_sequence <= head[SEQ_LSB +: 8] | (8'h01 << NEXT_VALID_BIT);
      end
      if (push && i_entry_data[SEQ_LSB + LAST_FLAG_BIT]) begin
        o_queue_status[QS_END_BIT] <= 1'b1;
      end else if (push) begin
        o_queue_status[QS_END_BIT] <= 1'b0;
      end
      if (pop) begin
        o_queue_status[QS_RUN_BIT] <= 1'b1;
      end
      o_pending_entry_count <= 8'(count_reg + CW'(push) - CW'(pop));
    end
  end

  // Diagnostic record: request decode to a byte offset
  logic rec_ok;
  logic [4:0] rec_ofs;
  logic rec_capture;

  always_comb begin
    rec_ok = 1'b0;
    rec_ofs = i_rec_byte;
    case (i_rec_path)
      REC_SET: begin
        rec_ok = ((i_rec_id == RECORD_SET_FULL) && (i_rec_byte < RECORD_LEN)) ||
                 ((i_rec_id == RECORD_SET_SHORT) && (i_rec_byte < SHORT_LEN));
      end
      REC_CANOPEN: begin
        rec_ok = ((i_rec_id == CAN_INDEX_FULL) && (i_rec_byte < RECORD_LEN)) ||
                 ((i_rec_id == CAN_INDEX_SHORT) && (i_rec_byte < SHORT_LEN));
      end
      REC_ETHERCAT: begin
        if (i_rec_id == ECAT_INDEX && i_rec_sub >= ECAT_SUB_FIRST &&
            i_rec_sub <= ECAT_SUB_LAST_ERR && i_rec_byte == 5'h00) begin
          rec_ok = 1'b1;
          rec_ofs = 5'(i_rec_sub - ECAT_SUB_FIRST);
        end else if (i_rec_id == ECAT_INDEX && i_rec_sub == ECAT_SUB_TICKER &&
                     i_rec_byte < SHORT_LEN) begin
          rec_ok = 1'b1;
          rec_ofs = TICKER_OFS + i_rec_byte;
        end
      end
      default: begin
        rec_ok = 1'b0;
      end
    endcase
  end

  // Ticker snapshot when a read starts its record, or its ticker field on the EtherCAT path only
  assign rec_capture = i_rec_valid && rec_ok &&
                       (rec_ofs == 5'h00 || (i_rec_path == REC_ETHERCAT && rec_ofs == TICKER_OFS));

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ts_reg <= 32'h0000_0000;
    end else if (rec_capture) begin
      ts_reg <= i_us_ticker;
    end
  end

  function automatic logic [7:0] rec_byte(input logic [4:0] ofs, input logic [31:0] ts);
    case (ofs)
      5'h00: rec_byte = ERROR_BYTE_A_VAL;
      5'h01: rec_byte = MODULE_CLASS_INFO_VAL;
      5'h02: rec_byte = ERROR_BYTE_C_VAL;
      5'h03: rec_byte = ERROR_BYTE_D_VAL;
      5'h04: rec_byte = CHANNEL_KIND_VAL;
      5'h05: rec_byte = DIAG_BITS_PER_CHANNEL_VAL;
      5'h06: rec_byte = CHANNEL_COUNT_VAL;
      5'h07: rec_byte = CHANNEL_ERROR_SUMMARY_VAL;
      5'h10: rec_byte = ts[7:0];
      5'h11: rec_byte = ts[15:8];
      5'h12: rec_byte = ts[23:16];
      5'h13: rec_byte = ts[31:24];
      default: rec_byte = PER_CHANNEL_ERRORS_VAL;
    endcase
  endfunction

  // Answer one cycle after the request; no interrupt path exists
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rec_valid <= 1'b0;
      o_rec_data <= 8'h00;
      o_rec_err <= 1'b0;
    end else begin
      o_rec_valid <= i_rec_valid;
      o_rec_err <= i_rec_valid && !rec_ok;
      if (i_rec_valid) begin
        o_rec_data <= rec_ok ? rec_byte(rec_ofs, rec_capture ? i_us_ticker : ts_reg) : 8'h00;
      end
    end
  end

  // Checks
  sequence s_push_alone;
    push && !pop;
  endsequence
  sequence s_count_up;
    count_reg == $past(count_reg) + 1'b1;
  endsequence
  sequence s_rec_good;
    o_rec_valid && !o_rec_err;
  endsequence
  sequence s_rec_bad;
    o_rec_valid && o_rec_err && o_rec_data == 8'h00;
  endsequence

  a_push_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
    s_push_alone |=> s_count_up) else $error("count did not rise on push");
  a_ready_level: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_entry_ready == (count_reg < CW'(DEPTH))) else $error("ready disagrees with fill");
  a_pop_time: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pop |-> i_ticker_present && i_us_ticker[TIME_W-1:0] == head[TIME_LSB +: TIME_W])
    else $error("entry applied off time");
  a_pop_frees: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pop |=> o_entry_ready) else $error("applied entry not removed");
  a_hold_outputs: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !pop |=> $stable(o_do)) else $error("outputs moved without an entry");
  a_no_ticker_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_ticker_present |-> !pop) else $error("applied without ticker");
  a_pop_outputs: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pop |=> o_do == ($past(st_next) & $past(en_next)))
    else $error("outputs not from applied entry");
  a_pop_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pop && !push |=> o_pending_entry_count == 8'($past(count_reg) - 1'b1))
    else $error("pending count not lowered");
  a_pending_mirror: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_pending_entry_count == 8'(count_reg)) else $error("pending count off fill");
  a_last_seq: assert property (@(posedge i_clk) disable iff (!i_nrst)
    push |=> o_last_received_sequence == $past(i_entry_data[SEQ_LSB +: 8]))
    else $error("last received sequence wrong");
  a_end_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
    push |=> o_queue_status[QS_END_BIT] == $past(i_entry_data[SEQ_LSB + LAST_FLAG_BIT]))
    else $error("end of block flag wrong");
  a_run_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pop |=> o_queue_status[QS_RUN_BIT]) else $error("applied flag not set");

  // Record answers
  a_rec_answer: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_rec_valid |=> o_rec_valid ##1 (!o_rec_valid || $past(i_rec_valid)))
    else $error("record answer timing");
  a_rec_quiet: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_rec_valid |=> !o_rec_valid) else $error("record answer without request");
  a_short_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_rec_valid && i_rec_path == REC_SET && i_rec_id == 16'h0000 && i_rec_byte >= 5'h04
    |=> o_rec_err) else $error("short set served past four bytes");
  a_full_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_rec_valid && i_rec_path == REC_SET && i_rec_id == 16'h0001 && i_rec_byte == 5'h01
    |=> s_rec_good ##0 o_rec_data == 8'h1f) else $error("module info wrong");
  a_can_info: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_rec_valid && i_rec_path == REC_CANOPEN && i_rec_id == 16'h2f01 && i_rec_byte == 5'h04
    |=> o_rec_data == 8'h72 && !o_rec_err) else $error("channel kind wrong");
  a_can_short: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_rec_valid && i_rec_path == REC_CANOPEN && i_rec_id == 16'h2f00 && i_rec_byte >= 5'h04
    |=> s_rec_bad) else $error("short index served past four bytes");
  a_ecat_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_rec_valid && i_rec_path == REC_ETHERCAT && i_rec_id == 16'h5005 && i_rec_sub == 8'h08
    && i_rec_byte == 5'h00 |=> o_rec_data == 8'h02) else $error("channel count wrong");
  a_bits_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_rec_valid && i_rec_path == REC_SET && i_rec_id == 16'h0001 && i_rec_byte == 5'h05
    |=> s_rec_good ##0 o_rec_data == 8'h00) else $error("diagnostic bit count wrong");
  a_ts_capture: assert property (@(posedge i_clk) disable iff (!i_nrst)
    rec_capture |=> ts_reg == $past(i_us_ticker)) else $error("ticker not captured");
  a_ts_fresh: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_rec_valid && i_rec_path == REC_ETHERCAT && i_rec_id == 16'h5005 && i_rec_sub == 8'h13
    && i_rec_byte == 5'h00 |=> s_rec_good ##0 o_rec_data == $past(i_us_ticker[7:0]))
    else $error("ticker byte not fresh");
endmodule : timed_output_fifo_diag
`default_nettype wire

// File: sim/head_ticker_model.sv
// Head module model: free running microsecond ticker with a presence flag.
// Assumes the bench owns presence; one tick per clock keeps runs short.
`timescale 1ns/10ps
`default_nettype none
module head_ticker_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Control from the bench
  input wire logic i_present,
  // Ticker towards the block
  output logic o_ticker_present,
  output logic [31:0] o_us_ticker
);
  assign o_ticker_present = i_present;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_us_ticker <= 32'h0000_0000;
    end else begin
      o_us_ticker <= o_us_ticker + 32'h0000_0001;
    end
  end
endmodule : head_ticker_model
`default_nettype wire

// File: sim/test_timed_output_fifo_diag.sv
// Bench for the timed output queue: entry push, timed apply order, record reads.
// Assumes the package and the head ticker model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module test_timed_output_fifo_diag;
  import timed_output_fifo_diag_pkg::*;
  logic i_clk = 1'b0, i_nrst = 1'b0, present = 1'b0;
  logic i_entry_valid = 1'b0, i_rec_valid = 1'b0;
  logic [31:0] i_entry_data = 32'h0, cap = 32'h0;
  rec_path_t i_rec_path = REC_SET;
  logic [15:0] i_rec_id = 16'h0, t;
  logic [7:0] i_rec_sub = 8'h0;
  logic [7:0] bits, seqn;
  logic [4:0] i_rec_byte = 5'h0;
  logic i_ticker_present, o_entry_ready, o_rec_valid, o_rec_err;
  logic [31:0] i_us_ticker, d [3];
  logic [1:0] o_do;
  logic [7:0] o_last_received_sequence, o_next_execute_sequence, o_queue_status;
  logic [7:0] o_pending_entry_count, o_rec_data;
  logic [8:0] notes [$];
  int num_errors = 0, checks = 0;
  head_ticker_model i_head_ticker_model (.i_clk(i_clk), .i_nrst(i_nrst), .i_present(present),
    .o_ticker_present(i_ticker_present), .o_us_ticker(i_us_ticker));
  timed_output_fifo_diag #(.DEPTH(4)) i_timed_output_fifo_diag (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_entry_valid(i_entry_valid), .i_entry_data(i_entry_data), .o_entry_ready(o_entry_ready),
    .i_ticker_present(i_ticker_present), .i_us_ticker(i_us_ticker), .o_do(o_do),
    .o_last_received_sequence(o_last_received_sequence),
    .o_next_execute_sequence(o_next_execute_sequence), .o_queue_status(o_queue_status),
    .o_pending_entry_count(o_pending_entry_count), .i_rec_valid(i_rec_valid),
    .i_rec_path(i_rec_path), .i_rec_id(i_rec_id), .i_rec_sub(i_rec_sub),
    .i_rec_byte(i_rec_byte), .o_rec_valid(o_rec_valid), .o_rec_data(o_rec_data),
    .o_rec_err(o_rec_err));
  always #25 i_clk = ~i_clk;
  task automatic finish_test;
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  function automatic logic [7:0] rec_byte(input int k);
    case (k)
      1: return 8'h1f;
      4: return 8'h72;
      6: return 8'h02;
      16, 17, 18, 19: return cap[8*(k-16) +: 8];
      default: return 8'h00;
    endcase
  endfunction : rec_byte
  // One record byte request; the note holds the expected error flag and byte
  task automatic rd(input rec_path_t p, input logic [15:0] id, input logic [7:0] s,
      input int b, input logic e);
    int off;
    off = (p != REC_ETHERCAT) ? b : (s == 8'h13) ? 16 + b : int'(s) - 2;
    @(posedge i_clk);
    #2;
    if (!e && (off == 0 || (p == REC_ETHERCAT && off == 16))) cap = i_us_ticker;
    i_rec_valid = 1'b1;
    i_rec_path = p;
    i_rec_id = id;
    i_rec_sub = s;
    i_rec_byte = b[4:0];
    notes.push_back({e, e ? 8'h00 : rec_byte(off)});
    @(posedge i_clk);
    #2;
    i_rec_valid = 1'b0;
  endtask : rd
  task automatic put(input logic [31:0] v);
    @(posedge i_clk);
    #2;
    {i_entry_valid, i_entry_data} = {1'b1, v};
  endtask : put
  task automatic idle;
    @(posedge i_clk);
    #2;
    i_entry_valid = 1'b0;
  endtask : idle
  task automatic wait_count(input logic [7:0] n);
    int i;
    for (i = 0; i < 300 && o_pending_entry_count !== n; i++) begin
      @(posedge i_clk);
      #2;
    end
    if (i == 300) begin
      num_errors++;
      finish_test();
    end
  endtask : wait_count
  always @(posedge i_clk) begin
    if (o_rec_valid === 1'b1) begin
      if (notes.size() == 0) chk("rec_extra", 1, 0);
      else chk("rec", {o_rec_err, o_rec_data}, notes.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h9cea));
    repeat (12) @(posedge i_clk);
    #2;
    i_nrst = 1'b1;
    chk("ready", o_entry_ready, 1);
    chk("outputs", {o_do, o_pending_entry_count, o_queue_status}, 0);
    for (int k = 0; k < 21; k++) rd(REC_SET, 16'h0001, 8'h00, k, k > 19);
    for (int k = 0; k < 5; k++) rd(REC_SET, 16'h0000, 8'h00, k, k > 3);
    for (int k = 0; k < 21; k++) rd(REC_CANOPEN, 16'h2f01, 8'h00, k, k > 19);
    for (int k = 0; k < 5; k++) rd(REC_CANOPEN, 16'h2f00, 8'h00, k, k > 3);
    for (int s = 2; s < 21; s++) rd(REC_ETHERCAT, 16'h5005, s[7:0], 0, s == 18 || s == 20);
    for (int k = 0; k < 5; k++) rd(REC_ETHERCAT, 16'h5005, 8'h13, k, k > 3);
    rd(REC_ETHERCAT, 16'h5005, 8'h03, 1, 1'b1);
    rd(REC_SET, 16'h0002 + 16'($urandom_range(200)), 8'h00, 0, 1'b1);
    rd(REC_CANOPEN, 16'h2f02, 8'h00, 0, 1'b1);
    // Fill past depth with no ticker present: fifth entry refused, nothing applies
    t = i_us_ticker[15:0] + 16'h0014;
    for (int i = 1; i < 6; i++) put({t, i[7:0], 8'hf0});
    idle();
    @(posedge i_clk);
    #2;
    chk("count_full", {o_entry_ready, o_pending_entry_count}, 9'h004);
    chk("last_seq", o_last_received_sequence, 8'h04);
    chk("next_seq", o_next_execute_sequence, 8'h81);
    repeat (40) @(posedge i_clk);
    #2;
    chk("no_ticker", o_pending_entry_count, 8'h04);
    i_nrst = 1'b0;
    @(posedge i_clk);
    #2;
    i_nrst = 1'b1;
    chk("reset_again", {o_entry_ready, o_pending_entry_count}, 9'h100);
    chk("reset_status", {o_do, o_queue_status, o_next_execute_sequence}, 0);
    // Short block with flagged last entry, applied in order against the ticker
    present = 1'b1;
    t = i_us_ticker[15:0];
    for (int i = 0; i < 3; i++) begin
      bits = 8'($urandom) & 8'hf0;
      bits = bits | ((bits >> 2) & 8'h30);
      seqn = (i == 2) ? 8'h4b : 8'h09 + i[7:0];
      d[i] = {t + 16'(40 * i + 40), seqn, bits};
      put(d[i]);
    end
    idle();
    chk("last_flag", {o_queue_status[7], o_last_received_sequence}, 9'h14b);
    for (int i = 0; i < 3; i++) begin
      wait_count(8'(2 - i));
      chk("apply", o_do, {d[i][6] & d[i][4], d[i][7] & d[i][5]});
    end
    chk("applied_flag", o_queue_status[1], 1);
    chk("notes_left", notes.size(), 0);
    finish_test();
  end
endmodule : test_timed_output_fifo_diag
`default_nettype wire
